// >>> inc/sfa_pkg.sv
// Package for the slave-axis synchronisation follower: offsets, fields, reset values, timing
package sfa_pkg;
  // Register byte offsets on the AHB-Lite window
  localparam logic [8:0] OFF_CTRL     = 9'h000;
  localparam logic [8:0] OFF_CMD      = 9'h004;
  localparam logic [8:0] OFF_AXES     = 9'h008;
  localparam logic [8:0] OFF_TSEL     = 9'h00c;
  localparam logic [8:0] OFF_CYCLE    = 9'h010;
  localparam logic [8:0] OFF_LOFF     = 9'h014;
  localparam logic [8:0] OFF_FOFF     = 9'h018;
  localparam logic [8:0] OFF_LSCALE   = 9'h01c;
  localparam logic [8:0] OFF_FSCALE   = 9'h020;
  localparam logic [8:0] OFF_GNUM     = 9'h024;
  localparam logic [8:0] OFF_GDEN     = 9'h028;
  localparam logic [8:0] OFF_SPEED    = 9'h02c;
  localparam logic [8:0] OFF_PCOUNT   = 9'h030;
  localparam logic [8:0] OFF_STATUS   = 9'h034;
  localparam logic [8:0] OFF_TARGET   = 9'h038;
  // Point window: addr[8]=1, point index addr[7:4], field addr[3:2]
  localparam int         PT_BIT       = 8;
  localparam logic [1:0] FLD_X        = 2'h0;
  localparam logic [1:0] FLD_Y        = 2'h1;
  localparam logic [1:0] FLD_SPAN     = 2'h2;
  localparam logic [1:0] FLD_SLOPE    = 2'h3;
  localparam int         NPTS         = 16;
  localparam int         NENT         = 32;
  // Command bits, status bits
  localparam int         CMD_ENGAGE   = 0;
  localparam int         CMD_STOP     = 1;
  localparam int         ST_SYNC_BIT  = 0;
  localparam int         ST_BUSY_BIT  = 1;
  localparam int         ST_DONE_BIT  = 2;
  localparam int         ST_REJ_BIT   = 3;
  localparam int         ST_LOCK_BIT  = 4;
  // Coupling modes
  localparam logic [1:0] MODE_CAM     = 2'h0;
  localparam logic [1:0] MODE_GEAR    = 2'h1;
  localparam logic [1:0] MODE_GANTRY  = 2'h2;
  // Reset values
  localparam logic [3:0]  RST_SLAVE   = 4'h0;
  localparam logic [3:0]  RST_MASTER  = 4'h1;
  localparam logic [31:0] RST_CYCLE   = 32'd10000;
  localparam logic [31:0] RST_SCALE   = 32'h0000_0100;
  localparam logic [31:0] RST_RATIO   = 32'h0000_0001;
  localparam logic [31:0] RST_SPEED   = 32'h0000_0010;
  localparam logic signed [7:0] SLOPE_MAX = 8'sd10;
  localparam logic signed [7:0] SLOPE_MIN = -8'sd10;
  localparam int         SCALE_FRAC   = 8;
  // Update period
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         TICK_US       = 1000;
  localparam int         TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  // Follower state
  typedef enum logic {SFA_READY, SFA_SYNC} sfa_state_e;
  // Coupling configuration word
  typedef struct packed {
    logic       gantry_opp;
    logic       periodic;
    logic       slave_abs;
    logic       master_abs;
    logic       ref_fb;
    logic [1:0] mode;
  } sfa_ctrl_s;
  // Positions from the axes
  typedef struct packed {
    logic signed [31:0] master_cmd;
    logic signed [31:0] master_fb;
    logic signed [31:0] slave_pos;
  } sfa_pos_s;
endpackage : sfa_pkg

// >>> src/sfa_follower.sv
// Slave-axis follower: cam, gear and gantry coupling behind an AHB-Lite register slave
//
// Overview of operation
// - Slave and master axis may never be equal; slave axis resets to axis 0.
// - Cam table starts at (0,0) and ends at (cycle length,0); only point 0 is pinned, the end point is not forced.
// - Each stored slope saturates to the range -10 to 10.
// - Master cycle length resets to 10000 pulses.
// - Changing cycle length rescales every point's master coordinate and span.
// - Table select is 0 or 1, set before storing, frozen until stop.
// - Non-periodic cam stops following after one full master cycle; the target holds while sync and the following output stay set.
// - Periodic cam repeats the profile every master cycle while engaged.
// - Absolute master mode uses the master position directly as cam abscissa.
// - Relative master mode measures master travel from the engage position.
// - Absolute slave mode chases the table value at the set speed.
// - Relative slave mode adds the profile to the engage position.
// - Leader/follower offsets and scales shift and stretch the profile.
// - Master reference is the command or the feedback position.
// - Cam engage enters synchronous driving and tracks the master.
// - Stop dissolves cam coupling and returns to ready.
// - Gear mode follows master travel times numerator over denominator.
// - Absolute gear chases the scaled master position at the set speed.
// - Relative gear keeps the engage-time position difference.
// - Gantry follows the master in same or opposite direction.
// - Gear or gantry engage tracks the master; stop returns to ready.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sfa_follower #(
  parameter int TICK_CYCLES = sfa_pkg::TICK_CYCLES
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire sfa_pkg::sfa_pos_s pos,
  output logic signed [31:0]     slave_target,
  output logic                   following,
  output logic [3:0]             slave_axis,
  output logic [3:0]             master_axis
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Multiply then divide, shared by gear and rescale
  function automatic logic signed [31:0] muldiv(input logic signed [31:0] a, input logic signed [31:0] b,
                                                input logic signed [31:0] c);
    logic signed [63:0] p;
    p = a * b;
    if (c == 32'sh0) return a;
    return 32'(p / c);
  endfunction : muldiv

  // Step toward a goal by at most spd per tick
  function automatic logic signed [31:0] chase(input logic signed [31:0] cur, input logic signed [31:0] goal,
                                               input logic signed [31:0] spd);
    if (goal > cur + spd) return cur + spd;
    if (goal < cur - spd) return cur - spd;
    return goal;
  endfunction : chase

  // Fixed-point Q8 scale
  function automatic logic signed [31:0] qscale(input logic signed [31:0] v, input logic signed [31:0] s);
    logic signed [63:0] p;
    p = v * s;
    return p[39:8];
  endfunction : qscale

  // Point tables, both selectors side by side
  logic signed [31:0] px [0:sfa_pkg::NENT-1];
  logic signed [31:0] py [0:sfa_pkg::NENT-1];
  logic signed [31:0] pspan [0:sfa_pkg::NENT-1];
  logic signed [7:0]  pslope [0:sfa_pkg::NENT-1];

  sfa_pkg::sfa_ctrl_s ctrl, next_ctrl;
  sfa_pkg::sfa_state_e state, next_state;
  logic [3:0]  next_slave_axis, next_master_axis;
  logic        table_sel, next_table_sel, table_lock, next_table_lock;
  logic signed [31:0] cycle_len, next_cycle_len, old_len, next_old_len;
  logic signed [31:0] loff, next_loff, foff, next_foff, lscale, next_lscale, fscale, next_fscale;
  logic signed [31:0] gnum, next_gnum, gden, next_gden, speed, next_speed;
  logic [4:0]  pcount, next_pcount;
  logic        reject_err, next_reject_err, busy, next_busy;
  logic [4:0]  rs_idx, next_rs_idx;
  logic        dp_we, next_dp_we;
  logic [8:0]  dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic        engage_ok, stop_wr, pt_wr;
  logic signed [7:0] sat_slope;

  // Motion state
  logic signed [31:0] ref0, next_ref0, slave0, next_slave0, cyc_base, next_cyc_base;
  logic signed [31:0] next_slave_target;
  logic [3:0]  idx, next_idx;
  logic        done, next_done;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic        tick, next_tick;
  logic signed [31:0] mref, xr, xc, yv, ys, gear_goal, gantry_goal;
  logic [4:0]  ent, ent_n;

  // Bus and configuration: address phase captured, write applied in data phase
  always_comb begin
    logic [31:0] aw;
    aw = 32'h0;
    next_ctrl = ctrl; next_slave_axis = slave_axis; next_master_axis = master_axis;
    next_table_sel = table_sel; next_table_lock = table_lock; next_cycle_len = cycle_len;
    next_old_len = old_len; next_loff = loff; next_foff = foff; next_lscale = lscale;
    next_fscale = fscale; next_gnum = gnum; next_gden = gden; next_speed = speed;
    next_pcount = pcount; next_reject_err = reject_err; next_busy = busy; next_rs_idx = rs_idx;
    next_dp_we = hsel && htrans[1] && hready && hwrite;
    next_dp_addr = haddr[8:0];
    next_hrdata = hrdata;
    engage_ok = 1'b0;
    stop_wr = 1'b0;
    pt_wr = dp_we && dp_addr[sfa_pkg::PT_BIT] && !busy;
    if (busy) begin
      next_rs_idx = rs_idx + 5'h1;
      if (rs_idx == 5'(sfa_pkg::NENT - 1)) next_busy = 1'b0;
    end
    if (pt_wr) next_table_lock = 1'b1; // Storing a table freezes the selector
    if (dp_we && !dp_addr[sfa_pkg::PT_BIT]) begin
      unique case (dp_addr)
        sfa_pkg::OFF_CTRL:   next_ctrl = sfa_pkg::sfa_ctrl_s'(hwdata[6:0]);
        sfa_pkg::OFF_CMD: begin
          stop_wr = hwdata[sfa_pkg::CMD_STOP];
          engage_ok = hwdata[sfa_pkg::CMD_ENGAGE] && !stop_wr && state == sfa_pkg::SFA_READY && !busy
                      && ctrl.mode != 2'h3; // Illegal mode never engages
          if (stop_wr) next_table_lock = 1'b0; // Dissolving releases the selector
        end
        sfa_pkg::OFF_AXES: begin
          if (hwdata[3:0] == hwdata[11:8] || state == sfa_pkg::SFA_SYNC) next_reject_err = 1'b1;
          else begin
            next_slave_axis = hwdata[3:0];
            next_master_axis = hwdata[11:8];
          end
        end
        sfa_pkg::OFF_TSEL:   if (!table_lock && state == sfa_pkg::SFA_READY) next_table_sel = hwdata[0];
        sfa_pkg::OFF_CYCLE: begin
          if (!busy && state == sfa_pkg::SFA_READY && hwdata != 32'h0) begin
            next_old_len = cycle_len;
            next_cycle_len = hwdata;
            next_busy = 1'b1; // Walk all points to rescale them
            next_rs_idx = 5'h0;
          end
        end
        sfa_pkg::OFF_LOFF:   next_loff = hwdata;
        sfa_pkg::OFF_FOFF:   next_foff = hwdata;
        sfa_pkg::OFF_LSCALE: next_lscale = hwdata;
        sfa_pkg::OFF_FSCALE: next_fscale = hwdata;
        sfa_pkg::OFF_GNUM:   next_gnum = hwdata;
        sfa_pkg::OFF_GDEN:   next_gden = hwdata;
        sfa_pkg::OFF_SPEED:  next_speed = hwdata;
        sfa_pkg::OFF_PCOUNT: next_pcount = (hwdata > 32'(sfa_pkg::NPTS)) ? 5'(sfa_pkg::NPTS) : hwdata[4:0];
        sfa_pkg::OFF_STATUS: if (hwdata[sfa_pkg::ST_REJ_BIT]) next_reject_err = 1'b0;
        default: ;
      endcase
    end
    // Read data prepared in the address phase, zero for holes
    if (hsel && htrans[1] && hready && !hwrite) begin
      aw = haddr;
      if (aw[sfa_pkg::PT_BIT]) begin
        unique case (aw[3:2])
          sfa_pkg::FLD_X:     next_hrdata = px[{table_sel, aw[7:4]}];
          sfa_pkg::FLD_Y:     next_hrdata = py[{table_sel, aw[7:4]}];
          sfa_pkg::FLD_SPAN:  next_hrdata = pspan[{table_sel, aw[7:4]}];
          sfa_pkg::FLD_SLOPE: next_hrdata = 32'(pslope[{table_sel, aw[7:4]}]);
        endcase
      end else begin
        unique case (aw[8:0])
          sfa_pkg::OFF_CTRL:   next_hrdata = {25'h0, ctrl};
          sfa_pkg::OFF_AXES:   next_hrdata = {20'h0, master_axis, 4'h0, slave_axis};
          sfa_pkg::OFF_TSEL:   next_hrdata = {31'h0, table_sel};
          sfa_pkg::OFF_CYCLE:  next_hrdata = cycle_len;
          sfa_pkg::OFF_LOFF:   next_hrdata = loff;
          sfa_pkg::OFF_FOFF:   next_hrdata = foff;
          sfa_pkg::OFF_LSCALE: next_hrdata = lscale;
          sfa_pkg::OFF_FSCALE: next_hrdata = fscale;
          sfa_pkg::OFF_GNUM:   next_hrdata = gnum;
          sfa_pkg::OFF_GDEN:   next_hrdata = gden;
          sfa_pkg::OFF_SPEED:  next_hrdata = speed;
          sfa_pkg::OFF_PCOUNT: next_hrdata = {27'h0, pcount};
          sfa_pkg::OFF_STATUS: next_hrdata = {27'h0, table_lock, reject_err, done, busy, state == sfa_pkg::SFA_SYNC};
          sfa_pkg::OFF_TARGET: next_hrdata = slave_target;
          default:             next_hrdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0; slave_axis <= sfa_pkg::RST_SLAVE; master_axis <= sfa_pkg::RST_MASTER;
      table_sel <= 1'b0; table_lock <= 1'b0;
      cycle_len <= sfa_pkg::RST_CYCLE; old_len <= sfa_pkg::RST_CYCLE;
      loff <= '0; foff <= '0; lscale <= sfa_pkg::RST_SCALE; fscale <= sfa_pkg::RST_SCALE;
      gnum <= sfa_pkg::RST_RATIO; gden <= sfa_pkg::RST_RATIO; speed <= sfa_pkg::RST_SPEED;
      pcount <= 5'h2; reject_err <= 1'b0; busy <= 1'b0; rs_idx <= 5'h0;
      dp_we <= 1'b0; dp_addr <= 9'h0; hrdata <= 32'h0; hreadyout <= 1'b1; hresp <= 1'b0;
    end else begin
      ctrl <= next_ctrl; slave_axis <= next_slave_axis; master_axis <= next_master_axis;
      table_sel <= next_table_sel; table_lock <= next_table_lock;
      cycle_len <= next_cycle_len; old_len <= next_old_len;
      loff <= next_loff; foff <= next_foff; lscale <= next_lscale; fscale <= next_fscale;
      gnum <= next_gnum; gden <= next_gden; speed <= next_speed;
      pcount <= next_pcount; reject_err <= next_reject_err; busy <= next_busy; rs_idx <= next_rs_idx;
      dp_we <= next_dp_we; dp_addr <= next_dp_addr; hrdata <= next_hrdata;
      hreadyout <= 1'b1; hresp <= 1'b0; // Zero wait state, always OKAY
    end
  end

  // Slope clamped on its way in
  always_comb begin
    logic signed [31:0] w;
    w = hwdata;
    if (w < 32'(sfa_pkg::SLOPE_MIN)) sat_slope = sfa_pkg::SLOPE_MIN;
    else if (w > 32'(sfa_pkg::SLOPE_MAX)) sat_slope = sfa_pkg::SLOPE_MAX;
    else sat_slope = w[7:0];
  end

  // Point memory: bus writes, or the rescale walk; point 0 is pinned to the origin
  always_ff @(posedge hclk) begin
    if (busy) begin
      px[rs_idx]    <= muldiv(px[rs_idx], cycle_len, old_len);
      pspan[rs_idx] <= muldiv(pspan[rs_idx], cycle_len, old_len);
    end else if (pt_wr) begin
      unique case (dp_addr[3:2])
        sfa_pkg::FLD_X:     px[{table_sel, dp_addr[7:4]}] <= (dp_addr[7:4] == 4'h0) ? 32'sh0 : hwdata;
        sfa_pkg::FLD_Y:     py[{table_sel, dp_addr[7:4]}] <= (dp_addr[7:4] == 4'h0) ? 32'sh0 : hwdata;
        sfa_pkg::FLD_SPAN:  pspan[{table_sel, dp_addr[7:4]}] <= hwdata;
        sfa_pkg::FLD_SLOPE: pslope[{table_sel, dp_addr[7:4]}] <= sat_slope;
      endcase
    end
  end

  // Profile and coupling arithmetic for this tick
  always_comb begin
    mref = ctrl.ref_fb ? pos.master_fb : pos.master_cmd;
    xr = ctrl.master_abs ? mref : mref - ref0;
    xc = qscale(xr, lscale) + loff - cyc_base;
    ent = {table_sel, idx};
    ent_n = {table_sel, 4'(idx + 4'h1)};
    if (ent == {table_sel, 4'h0}) yv = 32'(pslope[ent]) * xc;
    else yv = py[ent] + 32'(pslope[ent]) * (xc - px[ent]);
    ys = qscale(yv, fscale) + foff;
    gear_goal = muldiv(mref, gnum, gden);
    gantry_goal = ctrl.gantry_opp ? slave0 - (mref - ref0) : slave0 + (mref - ref0);
  end

  // Motion sequencing and update divider
  always_comb begin
    next_state = state; next_ref0 = ref0; next_slave0 = slave0; next_cyc_base = cyc_base;
    next_idx = idx; next_done = done; next_slave_target = slave_target;
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h1;
    if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 32'h0;
      next_tick = 1'b1;
    end
    if (stop_wr) begin
      next_state = sfa_pkg::SFA_READY;
    end else if (engage_ok) begin
      next_state = sfa_pkg::SFA_SYNC;
      next_ref0 = mref;
      next_slave0 = pos.slave_pos;
      next_slave_target = pos.slave_pos;
      next_cyc_base = 32'sh0;
      next_idx = 4'h0;
      next_done = 1'b0;
    end else if (state == sfa_pkg::SFA_SYNC && tick) begin
      unique case (ctrl.mode)
        sfa_pkg::MODE_CAM: begin
          if (!done) begin
            if (xc >= cycle_len) begin
              if (ctrl.periodic) begin
                next_cyc_base = cyc_base + cycle_len;
                next_idx = 4'h0;
              end else next_done = 1'b1;
            end else begin
              if (5'(idx) + 5'h1 < pcount && xc >= px[ent_n]) next_idx = idx + 4'h1;
              next_slave_target = ctrl.slave_abs ? chase(slave_target, ys, speed) : slave0 + ys;
            end
          end
        end
        sfa_pkg::MODE_GEAR:
          next_slave_target = ctrl.slave_abs ? chase(slave_target, gear_goal, speed)
                                             : slave0 + gear_goal - muldiv(ref0, gnum, gden);
        sfa_pkg::MODE_GANTRY: next_slave_target = gantry_goal;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= sfa_pkg::SFA_READY; ref0 <= '0; slave0 <= '0; cyc_base <= '0;
      idx <= 4'h0; done <= 1'b0; slave_target <= '0; tick_cnt <= 32'h0; tick <= 1'b0;
      following <= 1'b0;
    end else begin
      state <= next_state; ref0 <= next_ref0; slave0 <= next_slave0; cyc_base <= next_cyc_base;
      idx <= next_idx; done <= next_done; slave_target <= next_slave_target;
      tick_cnt <= next_tick_cnt; tick <= next_tick;
      following <= (next_state == sfa_pkg::SFA_SYNC);
    end
  end

  // Checks

  sequence s_engage;
    engage_ok;
  endsequence
  sequence s_synced;
    state == sfa_pkg::SFA_SYNC && following;
  endsequence

  property p_axes_differ;
    slave_axis != master_axis;
  endproperty
  a_axes_differ: assert property (p_axes_differ) else $error("slave and master axis equal");

  property p_slope_sat;
    pt_wr && dp_addr[3:2] == sfa_pkg::FLD_SLOPE |=> pslope[{table_sel, $past(dp_addr[7:4])}] <= sfa_pkg::SLOPE_MAX
      && pslope[{table_sel, $past(dp_addr[7:4])}] >= sfa_pkg::SLOPE_MIN;
  endproperty
  a_slope_sat: assert property (p_slope_sat) else $error("stored slope outside limits");

  property p_origin;
    pt_wr && dp_addr[7:4] == 4'h0 && dp_addr[3:2] == sfa_pkg::FLD_X |=> px[{table_sel, 4'h0}] == 32'sh0;
  endproperty
  a_origin: assert property (p_origin) else $error("first point left origin");

  property p_tsel_lock;
    table_lock && !stop_wr |=> $stable(table_sel);
  endproperty
  a_tsel_lock: assert property (p_tsel_lock) else $error("table select moved while locked");

  property p_engage;
    s_engage |=> s_synced;
  endproperty
  a_engage: assert property (p_engage) else $error("engage did not enter sync");

  property p_stop;
    stop_wr |=> state == sfa_pkg::SFA_READY && !following;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not return to ready");

  property p_nonperiodic_hold;
    state == sfa_pkg::SFA_SYNC && ctrl.mode == sfa_pkg::MODE_CAM && done && !engage_ok |=> $stable(slave_target);
  endproperty
  a_nonperiodic_hold: assert property (p_nonperiodic_hold) else $error("follower moved after cycle end");

  property p_gantry;
    following && tick && ctrl.mode == sfa_pkg::MODE_GANTRY && !stop_wr |=> slave_target == $past(gantry_goal);
  endproperty
  a_gantry: assert property (p_gantry) else $error("gantry target wrong");

  property p_rescale;
    dp_we && dp_addr == sfa_pkg::OFF_CYCLE && !busy && state == sfa_pkg::SFA_READY && hwdata != 32'h0
      |=> busy [*8] ##24 busy ##1 !busy;
  endproperty
  a_rescale: assert property (p_rescale) else $error("rescale walk wrong length");
endmodule : sfa_follower
`default_nettype wire

// >>> tb/sfa_axes_model.sv
// Partner model: master axis trajectory, its encoder and the slave servo drive
`timescale 1ns/10ps
`default_nettype none
module sfa_axes_model #(
  parameter int SLAVE_HOME = 500
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic signed [31:0] goal,
  input  wire logic               hold_fb,
  input  wire logic signed [31:0] slave_target,
  input  wire logic               following,
  output var sfa_pkg::sfa_pos_s   pos
);
  // Master ramps one pulse a cycle; a stalled encoder is only seen on request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos <= '{master_cmd: 32'sd0, master_fb: 32'sd0, slave_pos: 32'(SLAVE_HOME)};
    end else begin
      if (pos.master_cmd < goal) pos.master_cmd <= pos.master_cmd + 32'sd1;
      if (pos.master_cmd > goal) pos.master_cmd <= pos.master_cmd - 32'sd1;
      if (!hold_fb) pos.master_fb <= pos.master_cmd;
      if (following) pos.slave_pos <= slave_target; // Drive holds still when uncoupled
    end
  end
endmodule : sfa_axes_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the slave-axis follower
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic [8:0] a; logic [31:0] e;} sfa_row_s;
  localparam sfa_row_s ROWS [10] = '{'{sfa_pkg::OFF_CYCLE, 32'd10000}, '{sfa_pkg::OFF_LSCALE, 32'h100},
    '{sfa_pkg::OFF_FSCALE, 32'h100}, '{sfa_pkg::OFF_GNUM, 32'h1}, '{sfa_pkg::OFF_GDEN, 32'h1},
    '{sfa_pkg::OFF_SPEED, 32'h10}, '{sfa_pkg::OFF_PCOUNT, 32'h2}, '{sfa_pkg::OFF_CMD, 32'h0},
    '{9'h03c, 32'h0}, '{sfa_pkg::OFF_STATUS, 32'h0}};
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hold_fb = 0, hreadyout, hresp, following;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic signed [31:0] goal = '0, slave_target;
  logic [3:0] slave_axis, master_axis;
  sfa_pkg::sfa_pos_s pos;
  int miscompares = 0, n_checks = 0, cycles = 0;
  int slave_now = 500;
  sfa_follower #(.TICK_CYCLES(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pos(pos), .slave_target(slave_target), .following(following),
    .slave_axis(slave_axis), .master_axis(master_axis));
  sfa_axes_model #(.SLAVE_HOME(500)) axes (.hclk(hclk), .hresetn(hresetn), .goal(goal), .hold_fb(hold_fb),
    .slave_target(slave_target), .following(following), .pos(pos));
  // Clock and a cycle ceiling so a stuck bus cannot hang the run
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  // One single AHB-Lite transfer; waits out hready in both phases
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {23'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk32(q, e);
    chk1(hresp, 1'b0); // Answer is always OKAY
  endtask : rd_chk
  // Engage, move the master, check the tracked target, then stop
  task automatic couple(input logic [31:0] ctrl, input int g, input int exp);
    bus(1'b1, sfa_pkg::OFF_CTRL, ctrl);
    bus(1'b1, sfa_pkg::OFF_CMD, 32'h1);
    #1 chk1(following, 1'b1);
    chk32(slave_target, 32'(slave_now));
    @(posedge hclk) goal <= g;
    repeat (240) @(posedge hclk); // Longest ramp is 200 pulses plus a tick
    #1 chk32(slave_target, 32'(exp));
    bus(1'b1, sfa_pkg::OFF_CMD, 32'h2);
    #1 chk1(following, 1'b0);
    slave_now = exp;
  endtask : couple
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk32({24'h0, master_axis, slave_axis}, 32'h10);
    for (int i = 0; i < 10; i++) rd_chk(ROWS[i].a, ROWS[i].e);
    // Equal axes refused and flagged; a distinct pair is taken
    bus(1'b1, sfa_pkg::OFF_AXES, 32'h202);
    #1 chk32({28'h0, slave_axis}, 32'h0);
    bus(1'b0, sfa_pkg::OFF_STATUS, 32'h0);
    chk32(q & 32'h8, 32'h8);
    bus(1'b1, sfa_pkg::OFF_AXES, 32'h305);
    #1 chk32({24'h0, master_axis, slave_axis}, 32'h35);
    // Table chosen first, then frozen once points are stored
    bus(1'b1, sfa_pkg::OFF_TSEL, 32'h0);
    bus(1'b1, 9'h11c, 32'd40);
    rd_chk(9'h11c, 32'ha);
    bus(1'b1, 9'h11c, 32'hffff_ffe0);
    rd_chk(9'h11c, 32'hffff_fff6);
    bus(1'b1, sfa_pkg::OFF_TSEL, 32'h1);
    rd_chk(sfa_pkg::OFF_TSEL, 32'h0);
    // First point pinned to the origin whatever is written
    bus(1'b1, 9'h100, 32'd1234);
    rd_chk(9'h100, 32'h0);
    // Doubling the cycle doubles stored abscissa and span
    bus(1'b1, 9'h110, 32'd1000);
    bus(1'b1, 9'h118, 32'd500);
    bus(1'b1, sfa_pkg::OFF_CYCLE, 32'd20000);
    repeat (40) @(posedge hclk);
    rd_chk(9'h110, 32'd2000);
    rd_chk(9'h118, 32'd1000);
    couple(32'h02, 100, 600);
    couple(32'h42, 300, 400);
    bus(1'b1, sfa_pkg::OFF_GNUM, 32'h3);
    couple(32'h01, 350, 550);
    // Stalled encoder: feedback reference must not move the slave
    @(posedge hclk) hold_fb <= 1'b1;
    couple(32'h05, 450, 550);
    // Cam with slope 2 on point 0: plain, then cut after one cycle, then wrapped
    bus(1'b1, 9'h10c, 32'd2);
    couple(32'h00, 500, 650);
    bus(1'b1, sfa_pkg::OFF_LOFF, 32'd20000);
    couple(32'h00, 550, 650);
    couple(32'h20, 600, 750);
    // Absolute gear with a 0x10000 step per tick lands on the ratio at once
    bus(1'b1, sfa_pkg::OFF_SPEED, 32'h0001_0000);
    couple(32'h11, 610, 1830);
    // Unassigned mode value cannot engage
    bus(1'b1, sfa_pkg::OFF_CTRL, 32'h3);
    bus(1'b1, sfa_pkg::OFF_CMD, 32'h1);
    #1 chk1(following, 1'b0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
